// ===== bench/dac_chk.sv
`default_nettype none
module dac_chk
	import dac_latch_pkg::*;
#(
	parameter int RESOLUTION = 16,
	parameter bit BIPOLAR = 1'b0
) (
	// Watched ports.
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic load_sel_n,
	input wire logic async_clear_n,
	input wire logic [RESOLUTION-1:0] dac_code,
	input wire logic [dac_latch_pkg::WORD_BITS-1:0] latch_word,
	input wire logic word_dropped
);
	import dac_latch_pkg::*;
	localparam logic [WORD_BITS-1:0] CLR = BIPOLAR ? MID_CODE : ZERO_CODE;
	// Quiet cycles with select high and core running, saturating.
	logic [5:0] hi_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst || !load_sel_n || !clk_en) begin
			hi_q <= 6'h00;
		end else if (hi_q != 6'h3F) begin
			hi_q <= hi_q + 6'h01;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_cleared; latch_word == CLR; endsequence
	sequence s_still; $stable(latch_word) [*3]; endsequence
	property p_clr; !async_clear_n |-> s_cleared; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_clr_code;
		!async_clear_n |-> dac_code == CLR[WORD_BITS-1 -: RESOLUTION];
	endproperty
	a_clr_code: assert property (p_clr_code) else $error("code");
	property p_code; dac_code == latch_word[WORD_BITS-1 -: RESOLUTION];
	endproperty
	a_code: assert property (p_code) else $error("bits");
	property p_late;
		$rose(load_sel_n) |=> $stable(latch_word) || !async_clear_n;
	endproperty
	a_late: assert property (p_late) else $error("early");
	property p_quiet;
		hi_q == 6'h3F && async_clear_n && $past(async_clear_n)
			|-> $stable(latch_word);
	endproperty
	a_quiet: assert property (p_quiet) else $error("stray");
	property p_rel;
		$rose(async_clear_n) && hi_q == 6'h3F |-> s_cleared ##1 s_still;
	endproperty
	a_rel: assert property (p_rel) else $error("lost");
	property p_en;
		!clk_en && !$past(clk_en) && async_clear_n |-> $stable(latch_word);
	endproperty
	a_en: assert property (p_en) else $error("gated");
	property p_drop; word_dropped |=> word_dropped; endproperty
	a_drop: assert property (p_drop) else $error("drop");
endmodule // dac_chk
bind serial_dac_input_latch dac_chk #(.RESOLUTION(RESOLUTION),
	.BIPOLAR(BIPOLAR)) i_chk (.core_clk(core_clk), .rst(rst),
	.clk_en(clk_en), .load_sel_n(load_sel_n), .dac_code(dac_code),
	.async_clear_n(async_clear_n), .latch_word(latch_word),
	.word_dropped(word_dropped));
`default_nettype wire

// ===== bench/host_model.sv
`default_nettype none
module host_model (
	// Serial link to the device.
	output logic sclk,
	output logic load_sel_n,
	output logic sdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk = 1'h0;
		load_sel_n = 1'h1;
		sdata = 1'h0;
	end
	// One frame; the clock stands low between frames.
	task automatic frame(input logic [31:0] d, input int n, input bit s);
		load_sel_n = s;
		for (int i = n - 1; i >= 0; i--) begin
			sdata = d[i];
			#6 sclk = 1'h1; // n is 16 or more
			#6 sclk = 1'h0;
		end
		#6 load_sel_n = 1'h1;
		sdata = ~sdata; // Released line must not look valid.
	endtask
endmodule // host_model
`default_nettype wire

// ===== bench/tb.sv
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	error_cnt++; $display("wrong value t=%0t %h %h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dac_latch_pkg::*;
	logic core_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, async_clear_n = 1'h1;
	logic sclk, load_sel_n, sdata, word_dropped;
	logic [13:0] dac_code;
	logic [WORD_BITS-1:0] latch_word, prev_q, w;
	logic [WORD_BITS-1:0] exp_q [$];
	logic [31:0] d;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	initial forever #5 core_clk = ~core_clk;
	host_model i_host (.sclk(sclk), .load_sel_n(load_sel_n), .sdata(sdata));
	serial_dac_input_latch #(.RESOLUTION(14), .BIPOLAR(1'h1)) i_dut (
		.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .sclk(sclk),
		.load_sel_n(load_sel_n), .sdata(sdata), .dac_code(dac_code),
		.async_clear_n(async_clear_n), .latch_word(latch_word),
		.word_dropped(word_dropped));
	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Each latch change outside a clear takes the oldest note.
	always @(negedge core_clk) begin
		if (!rst && async_clear_n && latch_word !== prev_q) begin
			w = exp_q.size() ? exp_q.pop_front() : ~latch_word;
			`CHK(latch_word, w)
			`CHK(dac_code, w[15:2])
		end
		prev_q = latch_word;
	end
	always @(posedge core_clk) if (++cyc == 20000) begin
		error_cnt++;
		report_and_stop();
	end
	initial begin
		void'($urandom(66));
		repeat (12) @(posedge core_clk);
		#1 rst = 1'h0;
		@(negedge core_clk);
		`CHK(latch_word, MID_CODE)
		for (int i = 0; i < 7; i++) begin
			d = $urandom();
			if (i < 6) exp_q.push_back(d[15:0]);
			@(posedge core_clk);
			#1;
			i_host.frame(d, 16 + (i % 3) * 4, i == 6);
			repeat (80) @(posedge core_clk);
		end
		`CHK(word_dropped, 1'h0)
		#1 async_clear_n = 1'h0;
		repeat (2) @(negedge core_clk);
		`CHK(latch_word, MID_CODE)
		@(posedge core_clk);
		#1 async_clear_n = 1'h1;
		clk_en = 1'h0;
		for (int i = 0; i < 17; i++) begin
			d = $urandom();
			if (i < 16) exp_q.push_back(d[15:0]);
			@(posedge core_clk);
			#1;
			i_host.frame(d, 16, 1'h0);
			repeat (20) @(posedge core_clk);
		end
		#1 clk_en = 1'h1;
		repeat (200) @(posedge core_clk);
		`CHK(word_dropped, 1'h1)
		`CHK(exp_q.size(), 0)
		report_and_stop();
	end
endmodule // tb
`default_nettype wire

// ===== hdl/dac_latch_pkg.sv
`default_nettype none

package dac_latch_pkg;

	// ------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------
	// Bits in one serial word.
	localparam int WORD_BITS = 16;
	// Width of the rising-edge counter, kept across frames until reset.
	localparam int CNT_BITS = 5;
	// Counter value at which sixteen framed edges have been counted since reset.
	localparam logic [CNT_BITS-1:0] FULL_COUNT = 5'h10;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	// Latch value after reset or clear in the unipolar variant.
	localparam logic [WORD_BITS-1:0] ZERO_CODE = 16'h0000;
	// Latch value after reset or clear in the bipolar variant.
	localparam logic [WORD_BITS-1:0] MID_CODE = 16'h8000;

	// ------------------------------------------------------------
	// Buffering and crossing
	// ------------------------------------------------------------
	// Depth of the word FIFO between the link and the core side.
	localparam int FIFO_DEPTH = 16;
	// Width of one FIFO pointer, one bit above the index.
	localparam int PTR_BITS = 5;

endpackage

`default_nettype wire

// ===== hdl/serial_dac_input_latch.sv
`default_nettype none

// ------------------------------------------------------------
// Word FIFO
// ------------------------------------------------------------
// Dual-clock FIFO with gray pointers. Flip-flop storage only.
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int PB = 5
) (
	// Write side, on the select edge clock.
	input wire logic wr_clk,
	input wire logic wr_rst,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	// Read side, on the core clock.
	input wire logic rd_clk,
	input wire logic rd_rst,
	input wire logic rd_en,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);

	// Binary to gray conversion, used on both pointers.
	function automatic logic [PB-1:0] to_gray(input logic [PB-1:0] b);
		to_gray = b ^ (b >> 1);
	endfunction

	// Storage and pointers.
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PB-1:0] wbin_q, wgray_q, rbin_q, rgray_q;
	// Two-stage synchronisers for each opposite pointer.
	logic [PB-1:0] rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;
	logic full, empty;

	// Full compares against the synchronised read pointer.
	assign full = (wgray_q == {~rg_s2_q[PB-1:PB-2], rg_s2_q[PB-3:0]});
	assign empty = (rgray_q == wg_s2_q);
	assign wr_ready = !full;
	assign rd_valid = !empty;
	assign rd_data = mem_q[rbin_q[PB-2:0]];

	// Write side state.
	always_ff @(posedge wr_clk or posedge wr_rst) begin
		if (wr_rst) begin
			wbin_q <= '0;
			wgray_q <= '0;
			rg_s1_q <= '0;
			rg_s2_q <= '0;
		end else begin
			rg_s1_q <= rgray_q;
			rg_s2_q <= rg_s1_q;
			if (wr_valid && !full) begin
				wbin_q <= wbin_q + 1'b1;
				wgray_q <= to_gray(PB'(wbin_q + 1'b1));
			end
		end
	end

	// Storage has no reset; it is only read once written.
	always_ff @(posedge wr_clk) begin
		if (wr_valid && !full) begin
			mem_q[wbin_q[PB-2:0]] <= wr_data;
		end
	end

	// Read side state; rd_en is the core clock enable.
	always_ff @(posedge rd_clk or posedge rd_rst) begin
		if (rd_rst) begin
			rbin_q <= '0;
			rgray_q <= '0;
			wg_s1_q <= '0;
			wg_s2_q <= '0;
		end else if (rd_en) begin
			wg_s1_q <= wgray_q;
			wg_s2_q <= wg_s1_q;
			if (rd_ready && !empty) begin
				rbin_q <= rbin_q + 1'b1;
				rgray_q <= to_gray(PB'(rbin_q + 1'b1));
			end
		end
	end

endmodule // word_fifo

// ------------------------------------------------------------
// Top: serial input and converter latch
// ------------------------------------------------------------
module serial_dac_input_latch
	import dac_latch_pkg::*;
#(
	parameter int RESOLUTION = 16,
	parameter bit BIPOLAR = 1'b0
) (
	// Core clock, reset and enable.
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Serial link from the host.
	input wire logic sclk,
	input wire logic load_sel_n,
	input wire logic sdata,
	// Asynchronous clear, active low.
	input wire logic async_clear_n,
	// Converter code and overflow flag.
	output logic [RESOLUTION-1:0] dac_code,
	output logic [dac_latch_pkg::WORD_BITS-1:0] latch_word,
	output logic word_dropped
);
	import dac_latch_pkg::*;

	// Clear or power-on value picked by variant.
	localparam logic [WORD_BITS-1:0] CLR_CODE =
		BIPOLAR ? MID_CODE : ZERO_CODE;

	// ------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------
	// Link-side state as one packed struct.
	typedef struct packed {
		logic [WORD_BITS-1:0] shreg;
		logic [CNT_BITS-1:0] cnt;
	} link_t;

	link_t link_q, link_d;
	// Toggles once for every complete word that met a full FIFO.
	logic drop_tgl_q;
	// High once sixteen rising edges have been counted since reset.
	logic word_done;
	logic fifo_wr_ready;

	// A frame is handed on once sixteen edges have been counted since reset.
	assign word_done = (link_q.cnt == FULL_COUNT);

	// Shift on each rising sclk while framed; the counter saturates.
	always_comb begin
		link_d = link_q;
		if (!load_sel_n) begin
			// Oldest bit falls off, so the last 16 remain.
			link_d.shreg = {link_q.shreg[WORD_BITS-2:0], sdata};
			if (link_q.cnt != FULL_COUNT) begin
				link_d.cnt = CNT_BITS'(link_q.cnt + 1'b1);
			end
		end
	end

	// Shift register runs on rising sclk only; a held-high select
	// leaves it untouched because the next state equals the current.
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			link_q <= '0;
		end else begin
			link_q <= link_d;
		end
	end

	// The rising select edge ends the frame and clocks the write side
	// of the FIFO. The link clock may stop here and the core may be
	// frozen, so no later edge is needed to keep the word. A word that
	// finds the FIFO full is counted by a toggle for the core side.
	always_ff @(posedge load_sel_n or posedge rst) begin
		if (rst) begin
			drop_tgl_q <= 1'b0;
		end else if (word_done && !fifo_wr_ready) begin
			drop_tgl_q <= ~drop_tgl_q;
		end
	end

	// Limitation: the edge counter saturates and is cleared only by
	// reset, so after the first full frame a short one is not refused.

	// ------------------------------------------------------------
	// Core domain
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] tgl_sync;
		logic [WORD_BITS-1:0] latch;
		logic dropped;
		logic [1:0] clr_sync;
	} core_t;

	core_t core_q, core_d;
	logic fifo_valid;
	logic [WORD_BITS-1:0] fifo_data;
	logic drop_evt;

	// Toggle edge seen after two synchroniser stages.
	assign drop_evt = core_q.tgl_sync[2] ^ core_q.tgl_sync[1];

	// A push with a full FIFO is noted as dropped.
	always_comb begin
		core_d = core_q;
		core_d.tgl_sync = {core_q.tgl_sync[1:0], drop_tgl_q};
		core_d.clr_sync = {core_q.clr_sync[0], 1'b1};
		if (drop_evt) begin
			core_d.dropped = 1'b1;
		end
		if (fifo_valid) begin
			core_d.latch = fifo_data;
		end
	end

	// Clear acts at once through the asynchronous input.
	always_ff @(posedge core_clk or posedge rst or negedge async_clear_n)
	begin
		if (rst) begin
			core_q <= '{tgl_sync: '0, latch: CLR_CODE, dropped: 1'b0,
				clr_sync: '0};
		end else if (!async_clear_n) begin
			core_q.latch <= CLR_CODE;
			core_q.clr_sync <= '0;
		end else if (clk_en) begin
			core_q <= core_d;
		end
	end

	// Words cross in a FIFO written from the select edge domain.
	word_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH),
		.PB(PTR_BITS)
	) u_fifo (
		.wr_clk(load_sel_n),
		.wr_rst(rst),
		.wr_valid(word_done),
		.wr_ready(fifo_wr_ready),
		.wr_data(link_q.shreg),
		.rd_clk(core_clk),
		.rd_rst(rst),
		.rd_en(clk_en),
		.rd_valid(fifo_valid),
		.rd_ready(async_clear_n),
		.rd_data(fifo_data)
	);

	// Left-justified code: upper bits drive the converter.
	assign dac_code = core_q.latch[WORD_BITS-1 -: RESOLUTION];
	assign latch_word = core_q.latch;
	assign word_dropped = core_q.dropped;

endmodule // serial_dac_input_latch

`default_nettype wire
